/* cfg_mirror_regs.vh */
// Constants for the configuration mirror: index timing, word layout,
// link status layout.
// Assumes inclusion by cfg_mirror.v only; cfg_word_store.v does not include it.
// How it works
// - Each index and its word stay on the bus for eight clocks.
// - Index walks 0 to F round robin so every word refreshes.
// - Mirror word is 32 bits, chosen by the current 4-bit index.
// - Index 0: device control high half, device control 2 low half.
// - Read request size in bits 14:12, payload in 7:5, codes 0 to 5.
// - Index 1: zero upper half, slot control lower half.
// - Index 2: primary link control high, secondary link control low.
// - Link status appears on status bits 46:31 every clock, at any index.
// - First-generation parts report bandwidth notification bit as 0.
// - Index 3: zero byte, command/status, root control low byte.
// - Indices 4 to B: secondary control, bus numbers, windows, MSI.
// - C power mgmt, D MSI-X/MSI, E CRC and map, F data and busdev.
// - Index E: CRC check enable bit 24, CRC generate enable bit 25.
// - Root-port-only fields are valid only in root port mode.
// - Link control fields mirror primary and second-gen registers.
// - Link status layout: bits 15..11 flags, 9:4 width, 3:0 speed.
`ifndef CFG_MIRROR_REGS_VH
`define CFG_MIRROR_REGS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HOLD_CYCLES 4'h8
`define IDX_LAST 4'hf

// ----------------------------------------------------------------
// Index codes
// ----------------------------------------------------------------
`define IDX_DEVCTL 4'h0
`define IDX_SLOT 4'h1
`define IDX_LINK 4'h2
`define IDX_CMD 4'h3
`define IDX_SEC 4'h4
`define IDX_IOBAS 4'h5
`define IDX_IOLIM 4'h6
`define IDX_MEMWIN 4'h7
`define IDX_PRBAS_LO 4'h8
`define IDX_PRBAS_HI 4'h9
`define IDX_PRLIM_LO 4'ha
`define IDX_PRLIM_HI 4'hb
`define IDX_PM 4'hc
`define IDX_MSIX 4'hd
`define IDX_CRC 4'he
`define IDX_BUSDEV 4'hf

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define READ_REQ_HI 14
`define READ_REQ_LO 12
`define PAYLOAD_HI 7
`define PAYLOAD_LO 5
`define SIZE_CODE_MAX 3'h5
`define LINK_BW_NOTIFY_BIT 10
`define CRC_CHECK_BIT 24
`define CRC_GEN_BIT 25
`define STS_LINK_HI 46
`define STS_LINK_LO 31
`define STS_WIDTH 47

`endif

/* cfg_word_store.v */
// Small register store that holds one 32-bit word per index.
// Assumes one clock, writes from same-domain logic; read data registered.
`timescale 1ns/1ps
module cfg_word_store #(
    parameter DEPTH_LOG2 = 4,
    parameter WIDTH = 32
) (
    input wire sys_clk,
    input wire wr_en,
    input wire [DEPTH_LOG2-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [DEPTH_LOG2-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);

reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

// Write port and registered read port
always @(posedge sys_clk) begin
    if (wr_en) begin
        mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
end

endmodule

/* cfg_mirror.v */
// Configuration space mirror: broadcasts sixteen 32-bit words of the
// core's configuration state, one per index, round robin.
// Assumes configuration fields come from core logic on sys_clk.
`timescale 1ns/1ps
`include "cfg_mirror_regs.vh"
module cfg_mirror #(
    parameter GEN1_ONLY = 1'b1,
    parameter ROOT_PORT = 1'b0
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [15:0] function_device_control,
    input wire [15:0] device_control_second,
    input wire [15:0] slot_control,
    input wire [15:0] link_control_primary,
    input wire [15:0] link_control_secondary,
    input wire [15:0] primary_command_status,
    input wire [7:0] root_control,
    input wire [15:0] secondary_control,
    input wire [7:0] secondary_bus,
    input wire [7:0] subordinate_bus,
    input wire [63:0] msg_interrupt_address,
    input wire [19:0] io_window_base,
    input wire [19:0] io_window_limit,
    input wire [11:0] memory_window_base,
    input wire [11:0] memory_window_limit,
    input wire [43:0] prefetch_window_base,
    input wire [43:0] prefetch_window_limit,
    input wire [31:0] power_mgmt_control_status,
    input wire [15:0] msgx_interrupt_control,
    input wire [15:0] msg_interrupt_control,
    input wire crc_check_enable,
    input wire crc_generate_enable,
    input wire [23:0] class_to_channel_map,
    input wire [15:0] msg_interrupt_data,
    input wire [12:0] bus_device_number,
    input wire [15:0] link_status,
    output reg [3:0] config_mirror_index,
    output reg [31:0] config_mirror_word,
    output reg [`STS_WIDTH-1:0] config_status_vector,
    output wire [31:0] stored_word
);

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------

// Clamp a size code to the legal 128..4096 byte range
function [2:0] clamp_size;
    input [2:0] code;
    begin
        if (code > `SIZE_CODE_MAX) begin
            clamp_size = `SIZE_CODE_MAX;
        end else begin
            clamp_size = code;
        end
    end
endfunction

// Blank a root-port-only field unless configured as root port
function [31:0] root_only;
    input [31:0] value;
    begin
        root_only = ROOT_PORT ? value : 32'h0000_0000;
    end
endfunction

// ----------------------------------------------------------------
// Index sequencer
// ----------------------------------------------------------------
reg [3:0] hold_count;
wire last_beat = (hold_count == `HOLD_CYCLES - 4'h1);

always @(posedge sys_clk) begin
    if (!rst_b) begin
        hold_count <= 4'h0;
        config_mirror_index <= 4'h0;
    end else if (last_beat) begin
        hold_count <= 4'h0;
        config_mirror_index <= config_mirror_index + 4'h1;
    end else begin
        hold_count <= hold_count + 4'h1;
    end
end

// ----------------------------------------------------------------
// Word assembly
// ----------------------------------------------------------------
// Root-port-only fields that share a word with always-valid fields
wire [7:0] root_ctl_m = ROOT_PORT ? root_control : 8'h00;
wire [19:0] io_base_m = ROOT_PORT ? io_window_base : 20'h00000;
wire [19:0] io_limit_m = ROOT_PORT ? io_window_limit : 20'h00000;
wire [11:0] pr_base_hi_m = ROOT_PORT ? prefetch_window_base[43:32] : 12'h000;
wire [11:0] pr_limit_hi_m =
    ROOT_PORT ? prefetch_window_limit[43:32] : 12'h000;
reg [15:0] devctl_fixed;
reg [15:0] linkctl_fixed;
reg [31:0] next_word;

always @* begin
    devctl_fixed = function_device_control;
    devctl_fixed[`READ_REQ_HI:`READ_REQ_LO] =
        clamp_size(function_device_control[`READ_REQ_HI:`READ_REQ_LO]);
    devctl_fixed[`PAYLOAD_HI:`PAYLOAD_LO] =
        clamp_size(function_device_control[`PAYLOAD_HI:`PAYLOAD_LO]);
    linkctl_fixed = link_control_primary;
    if (GEN1_ONLY) begin
        linkctl_fixed[`LINK_BW_NOTIFY_BIT] = 1'b0;
    end
end

// Word select for the index presented next
// Index selects word
always @* begin
    case (last_beat ? config_mirror_index + 4'h1 : config_mirror_index)
    `IDX_DEVCTL: next_word = {devctl_fixed, device_control_second};
    `IDX_SLOT: next_word = root_only({16'h0000, slot_control});
    `IDX_LINK: next_word = {linkctl_fixed, link_control_secondary};
    `IDX_CMD: next_word = {8'h00, primary_command_status, root_ctl_m};
    `IDX_SEC: next_word = root_only({secondary_control, secondary_bus,
        subordinate_bus});
    `IDX_IOBAS: next_word = {msg_interrupt_address[11:0], io_base_m};
    `IDX_IOLIM: next_word = {msg_interrupt_address[43:32], io_limit_m};
    `IDX_MEMWIN: next_word = root_only({8'h00, memory_window_base,
        memory_window_limit});
    `IDX_PRBAS_LO: next_word = root_only(prefetch_window_base[31:0]);
    `IDX_PRBAS_HI: next_word = {msg_interrupt_address[31:12],
        pr_base_hi_m};
    `IDX_PRLIM_LO: next_word = root_only(prefetch_window_limit[31:0]);
    `IDX_PRLIM_HI: next_word = {msg_interrupt_address[63:44],
        pr_limit_hi_m};
    `IDX_PM: next_word = power_mgmt_control_status;
    `IDX_MSIX: next_word = {msgx_interrupt_control, msg_interrupt_control};
    `IDX_CRC: next_word = {6'h00, crc_generate_enable, crc_check_enable,
        class_to_channel_map};
    default: next_word = {msg_interrupt_data, 3'h0, bus_device_number};
    endcase
end

// Register the word so it changes with the index
always @(posedge sys_clk) begin
    if (!rst_b) begin
        config_mirror_word <= 32'h0000_0000;
    end else if (last_beat) begin
        config_mirror_word <= next_word;
    end
end

// ----------------------------------------------------------------
// Status vector
// ----------------------------------------------------------------

always @(posedge sys_clk) begin
    if (!rst_b) begin
        config_status_vector <= {`STS_WIDTH{1'b0}};
    end else begin
        config_status_vector <= {`STS_WIDTH{1'b0}};
        config_status_vector[`STS_LINK_HI:`STS_LINK_LO] <= link_status;
    end
end

// ----------------------------------------------------------------
// Local copy of mirrored words
// ----------------------------------------------------------------
// Capture while stable
cfg_word_store #(
    .DEPTH_LOG2(4),
    .WIDTH(32)
) u_store (
    .sys_clk(sys_clk),
    .wr_en(rst_b && hold_count == `HOLD_CYCLES - 4'h2),
    .wr_addr(config_mirror_index),
    .wr_data(config_mirror_word),
    .rd_addr(config_mirror_index),
    .rd_data(stored_word)
);

endmodule

/* cfg_mirror_chk.sv */
// Checker for the configuration mirror outputs.
// Assumes a bind onto cfg_mirror built with GEN1_ONLY set.
`timescale 1ns/1ps
module cfg_mirror_chk (
    input wire sys_clk,
    input wire rst_b,
    input wire [15:0] link_status,
    input wire [3:0] config_mirror_index,
    input wire [31:0] config_mirror_word,
    input wire [46:0] config_status_vector
);
    // ------------------------------------------------
    // Index, word and status properties
    // ------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire [3:0] ix = config_mirror_index;
    wire [31:0] w = config_mirror_word;
    wire [46:0] sv = config_status_vector;
    chk_index_walk: assert property ($changed(ix) |-> ix == $past(ix) + 4'h1)
        else $error("index skipped");
    chk_index_hold: assert property ($changed(ix) |=> $stable(ix) [*7] ##1 $changed(ix))
        else $error("index hold wrong");
    chk_slot_zero: assert property (ix == 4'h1 |-> w[31:16] == 16'h0000)
        else $error("slot upper half set");
    chk_cmd_zero: assert property (ix == 4'h3 |-> w[31:24] == 8'h00)
        else $error("command top byte set");
    chk_crc_zero: assert property (ix == 4'he |-> w[31:26] == 6'h00)
        else $error("crc top bits set");
    chk_busdev_gap: assert property (ix == 4'hf |-> w[15:13] == 3'b000)
        else $error("bus number gap set");
    chk_bw_notify: assert property (ix == 4'h2 |-> !w[26])
        else $error("bandwidth notify set");
    chk_size_codes: assert property (ix == 4'h0 |-> w[30:28] <= 3'h5 && w[23:21] <= 3'h5)
        else $error("size code too big");
    chk_link_status: assert property ($past(rst_b) |-> sv == {$past(link_status), 31'h0})
        else $error("link status wrong");
    cover property (ix == 4'hf ##1 ix == 4'h0);
    cover property (ix == 4'he);
    cover property ($changed(sv));
endmodule

/* cfg_mirror_user.sv */
// User-side capture of mirrored words, one entry per index.
// Assumes index and word change together on sys_clk.
`timescale 1ns/1ps
module cfg_mirror_user (
    input wire sys_clk,
    input wire [3:0] idx,
    input wire [31:0] word
);
    reg [31:0] copy [0:15];
    reg [3:0] last_idx;
    always @(posedge sys_clk) begin
        last_idx <= idx;
        if (idx == last_idx)
            copy[idx] <= word;
    end
endmodule

/* tb_config_space_mirror_mux.sv */
// Self-checking bench for the configuration mirror.
// Assumes cfg_mirror, cfg_mirror_user and cfg_mirror_chk compiled first.
`timescale 1ns/1ps
module tb_config_space_mirror_mux;
    reg sys_clk;
    reg rst_b;
    reg [63:0] p;
    reg [15:0] ls;
    integer fails;
    integer total_checks;
    wire [3:0] idx;
    wire [31:0] word;
    wire [46:0] sts;
    wire [31:0] stw;
    cfg_mirror #(.GEN1_ONLY(1'b1), .ROOT_PORT(1'b1)) dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b),
        .function_device_control(p[63:48]), .device_control_second(p[15:0]),
        .slot_control(p[31:16]), .link_control_primary(p[47:32]),
        .link_control_secondary(p[23:8]), .primary_command_status(p[39:24]),
        .root_control(p[7:0]), .secondary_control(p[55:40]),
        .secondary_bus(p[15:8]), .subordinate_bus(p[63:56]),
        .msg_interrupt_address(p), .io_window_base(p[19:0]),
        .io_window_limit(p[43:24]), .memory_window_base(p[11:0]),
        .memory_window_limit(p[59:48]), .prefetch_window_base(p[43:0]),
        .prefetch_window_limit(p[63:20]), .power_mgmt_control_status(p[31:0]),
        .msgx_interrupt_control(p[47:32]), .msg_interrupt_control(p[15:0]),
        .crc_check_enable(p[3]), .crc_generate_enable(p[0]),
        .class_to_channel_map(p[23:0]), .msg_interrupt_data(p[31:16]),
        .bus_device_number(p[12:0]), .link_status(ls),
        .config_mirror_index(idx), .config_mirror_word(word),
        .config_status_vector(sts), .stored_word(stw));
    cfg_mirror_user u_user (.sys_clk(sys_clk), .idx(idx), .word(word));
    // Clock of 50 ns period
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Expected word for each index
    function [31:0] exp_word(input [3:0] i);
        case (i)
        4'h0: exp_word = {p[63:48], p[15:0]};
        4'h1: exp_word = {16'h0000, p[31:16]};
        4'h2: exp_word = {p[47:43], 1'b0, p[41:32], p[23:8]};
        4'h3: exp_word = {8'h00, p[39:24], p[7:0]};
        4'h4: exp_word = {p[55:40], p[15:8], p[63:56]};
        4'h5: exp_word = {p[11:0], p[19:0]};
        4'h6: exp_word = {p[43:32], p[43:24]};
        4'h7: exp_word = {8'h00, p[11:0], p[59:48]};
        4'h8: exp_word = p[31:0];
        4'h9: exp_word = {p[31:12], p[43:32]};
        4'ha: exp_word = p[51:20];
        4'hb: exp_word = {p[63:44], p[63:52]};
        4'hc: exp_word = p[31:0];
        4'hd: exp_word = {p[47:32], p[15:0]};
        4'he: exp_word = {6'h00, p[0], p[3], p[23:0]};
        default: exp_word = {p[31:16], 3'b000, p[12:0]};
        endcase
    endfunction
    task check(input [63:0] name, input [46:0] exp, input [46:0] got);
        begin
            total_checks = total_checks + 1;
            if (exp !== got) begin
                fails = fails + 1;
                $display("unexpected %0s exp %h got %h", name, exp, got);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d fails %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task walk_test;
        integer n;
        integer k;
        reg [3:0] prev;
        begin
            for (k = 0; k < 17; k = k + 1) begin
                prev = idx;
                n = 0;
                while (idx === prev && n < 20) begin
                    @(posedge sys_clk);
                    #1;
                    n = n + 1;
                end
                if (n == 20) begin
                    fails = fails + 1;
                    finish_test;
                end
                if (k > 0) check("hold", 47'd8, n[46:0]);
                check("index", {43'h0, prev + 4'h1}, {43'h0, idx});
            end
        end
    endtask
    task layout_test(input [63:0] v);
        integer i;
        integer n;
        reg [3:0] prev;
        begin
            p = v;
            repeat (300) @(posedge sys_clk);
            #1;
            for (i = 0; i < 16; i = i + 1)
                check("word", exp_word(i), u_user.copy[i]);
            // Local copy read two clocks into the slot must equal the live word
            prev = idx;
            n = 0;
            while (idx === prev && n < 20) begin
                @(posedge sys_clk);
                #1;
                n = n + 1;
            end
            if (n == 20) begin
                fails = fails + 1;
                finish_test;
            end
            repeat (2) @(posedge sys_clk);
            #1;
            check("stored", {15'h0, word}, {15'h0, stw});
        end
    endtask
    task status_test(input [15:0] v);
        begin
            ls = v;
            @(posedge sys_clk);
            #1;
            check("status", {v, 31'h0}, sts);
        end
    endtask
    task reset_test;
        begin
            rst_b = 1'b0;
            repeat (2) @(posedge sys_clk);
            #1;
            check("rst", 47'h0, {11'h0, idx, word});
            rst_b = 1'b1;
            walk_test;
        end
    endtask
    // Main sequence
    initial begin
        rst_b = 1'b0;
        p = 64'h5ca5_9e37_b1d4_06f8;
        ls = 16'h0000;
        fails = 0;
        total_checks = 0;
        repeat (8) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        walk_test;
        layout_test(64'h5ca5_9e37_b1d4_06f8);
        layout_test(64'h0a03_6c1e_4f92_d7b9);
        status_test(16'ha5f3);
        status_test(16'h5a0c);
        reset_test;
        finish_test;
    end
endmodule
bind cfg_mirror cfg_mirror_chk u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .link_status(link_status),
    .config_mirror_index(config_mirror_index),
    .config_mirror_word(config_mirror_word),
    .config_status_vector(config_status_vector));
